// ---- core/wss_pkg.sv ----
package wss_pkg;
    localparam logic [14:0] ADDR_SRC_CH34 = 15'h026;
    localparam logic [14:0] ADDR_SRC_CH12 = 15'h027;
    localparam logic [14:0] ADDR_TIMEBASE = 15'h028;
    localparam logic [14:0] ADDR_PATLEN = 15'h029;
    localparam logic [15:0] SRC_SEL_RST = 16'h0101;
    localparam logic [15:0] TIMEBASE_RST = 16'h0111;
    localparam logic [15:0] PATLEN_RST = 16'h8000;
    localparam int SRC_HI_LSB = 8;
    localparam int SRC_LO_LSB = 0;
    localparam int GEN_HI_LSB = 12;
    localparam int GEN_LO_LSB = 4;
    localparam int MASK_HI_BIT = 11;
    localparam int SUM_HI_BIT = 10;
    localparam int MASK_LO_BIT = 3;
    localparam int SUM_LO_BIT = 2;
    localparam int HOLD_LSB = 8;
    localparam int PER_BASE_LSB = 4;
    localparam int DLY_BASE_LSB = 0;
    localparam int MOD_LSB = 11;
    localparam logic [11:0] SAT_MAX = 12'h7ff;
    localparam logic [11:0] SAT_MIN = 12'h800;
    localparam logic [4:0] SPI_HALF_BITS = 5'h10;
    typedef enum logic [1:0] {
        SRC_MEM = 2'h0, SRC_GEN = 2'h1, SRC_GATED = 2'h2, SRC_MOD = 2'h3
    } wss_src_t;
    typedef enum logic [1:0] {
        GEN_CONST = 2'h0, GEN_RAMP = 2'h1, GEN_PRNG = 2'h2, GEN_SYNTH = 2'h3
    } wss_gen_t;
    typedef struct packed {
        wss_gen_t gen;
        wss_src_t src;
    } wss_chan_cfg_t;
    typedef struct packed {
        logic rd;
        logic [14:0] addr;
    } wss_spi_cmd_t;
    typedef enum logic [3:0] {
        SP_IDLE = 4'b0001, SP_CMD = 4'b0010, SP_DATA = 4'b0100,
        SP_DONE = 4'b1000
    } wss_spi_state_t;
endpackage : wss_pkg

// ---- core/wss_top.sv ----
// Behaviour
// - the source field picks memory, generator, gated or modulated data.
// - source fields sit at bits 9:8 and 1:0 and reset to the generator.
// - the generator field picks constant, sawtooth, random or synthesizer.
// - generator fields sit at bits 13:12 and 5:4 and reset to constant.
// - ch1/ch2 bits 11 and 3 force ch4 and ch3 to their constants.
// - ch1/ch2 bit 10 drives ch2 with the sum of ch2 and ch4.
// - ch1/ch2 bit 2 drives ch1 with the sum of ch1 and ch3, ch3 unchanged.
// - timebase bits 11:8 give the sample hold count, zero meaning one.
// - timebase bits 7:4 give clocks per pattern period unit, zero as one.
// - timebase bits 3:0 give clocks per start delay unit, zero as one.
// - a shared 16-bit period at 0x029, reset 0x8000, counts period units.
// - the constant for generator and mask is the channel's fixed_level_in input.
`timescale 1ns/10ps
module wss_top
    import wss_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_n_out,
    input wire logic pattern_run_in,
    input wire logic [3:0][11:0] mem_data_in,
    input wire logic [3:0][11:0] ramp_in,
    input wire logic [3:0][11:0] prng_in,
    input wire logic [3:0][11:0] synth_in,
    input wire logic [3:0][11:0] fixed_level_in,
    input wire logic [3:0][15:0] start_offset_in,
    output logic [3:0][11:0] dac_out,
    output logic [3:0] chan_active_out,
    output logic period_start_out
);
    function automatic logic [3:0] eff_scale(input logic [3:0] f);
        return (f == 4'h0) ? 4'h1 : f;
    endfunction : eff_scale
    function automatic logic [11:0] sat_add(input logic [11:0] a,
                                            input logic [11:0] b);
        logic [12:0] s;
        s = {a[11], a} + {b[11], b};
        if (s[12] != s[11]) begin
            return s[12] ? SAT_MIN : SAT_MAX;
        end
        return s[11:0];
    endfunction : sat_add
    // spi pins: two-stage synchronisers, logic reads only the second stage
    logic [2:0] pin_s1_q, pin_s2_q, pin_s1_d, pin_s2_d;
    logic sclk_prev_q, sclk_prev_d;
    always_comb begin
        pin_s1_d = {spi_cs_n_in, spi_sclk_in, spi_sdi_in};
        pin_s2_d = pin_s1_q;
        sclk_prev_d = pin_s2_q[1];
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_s1_q <= 3'h4;
            pin_s2_q <= 3'h4;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end
    logic cs_n, sclk_rise, sclk_fall, sdi;
    assign cs_n = pin_s2_q[2];
    assign sdi = pin_s2_q[0];
    assign sclk_rise = pin_s2_q[1] & ~sclk_prev_q;
    assign sclk_fall = ~pin_s2_q[1] & sclk_prev_q;
    // registers
    logic [15:0] src34_q, src12_q, tbase_q, patlen_q;
    logic [15:0] src34_d, src12_d, tbase_d, patlen_d;
    logic wr_en;
    logic [14:0] wr_addr;
    logic [15:0] wr_data;
    // serial port: 16-bit command (read flag, address) then 16-bit data
    wss_spi_state_t sp_q, sp_d;
    logic [4:0] bit_q, bit_d;
    logic [15:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d;
    wss_spi_cmd_t cmd_q, cmd_d;
    logic sdo_q, sdo_d;
    always_comb begin
        sp_d = sp_q;
        bit_d = bit_q;
        sh_in_d = sh_in_q;
        sh_out_d = sh_out_q;
        cmd_d = cmd_q;
        wr_en = 1'b0;
        if (sclk_rise) begin
            sh_in_d = {sh_in_q[14:0], sdi};
            bit_d = bit_q + 5'h1;
        end
        case (sp_q)
            SP_IDLE: begin
                bit_d = 5'h0;
                if (!cs_n) begin
                    sp_d = SP_CMD;
                end
            end
            SP_CMD: begin
                if (sclk_rise && bit_q == SPI_HALF_BITS - 5'h1) begin
                    cmd_d = {sh_in_q[14:0], sdi};
                    sh_out_d = rd_data_of({sh_in_q[13:0], sdi});
                    bit_d = 5'h0;
                    sp_d = SP_DATA;
                end
            end
            SP_DATA: begin
                // first fall comes before the first data rise: keep msb
                if (sclk_fall && bit_q != 5'h0) begin
                    sh_out_d = {sh_out_q[14:0], 1'b0};
                end
                if (sclk_rise && bit_q == SPI_HALF_BITS - 5'h1) begin
                    wr_en = ~cmd_q.rd;
                    sp_d = SP_DONE;
                end
            end
            SP_DONE: bit_d = 5'h0;
            default: sp_d = SP_IDLE;
        endcase
        if (cs_n) begin
            sp_d = SP_IDLE;
        end
        sdo_d = sh_out_d[15];
    end
    assign wr_addr = cmd_q.addr;
    assign wr_data = {sh_in_q[14:0], sdi};
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sp_q <= SP_IDLE;
            bit_q <= 5'h0;
            sh_in_q <= 16'h0000;
            sh_out_q <= 16'h0000;
            cmd_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            bit_q <= bit_d;
            sh_in_q <= sh_in_d;
            sh_out_q <= sh_out_d;
            cmd_q <= cmd_d;
            sdo_q <= sdo_d;
        end
    end
    assign spi_sdo_out = sdo_q;
    assign spi_sdo_oe_n_out = ~((sp_q == SP_DATA) && cmd_q.rd);

    function automatic logic [15:0] rd_data_of(input logic [14:0] a);
        case (a)
            ADDR_SRC_CH34: return src34_q;
            ADDR_SRC_CH12: return src12_q;
            ADDR_TIMEBASE: return tbase_q;
            ADDR_PATLEN: return patlen_q;
            default: return 16'h0000;
        endcase
    endfunction : rd_data_of

    always_comb begin
        src34_d = (wr_en && wr_addr == ADDR_SRC_CH34) ? wr_data : src34_q;
        src12_d = (wr_en && wr_addr == ADDR_SRC_CH12) ? wr_data : src12_q;
        tbase_d = (wr_en && wr_addr == ADDR_TIMEBASE) ? wr_data : tbase_q;
        patlen_d = (wr_en && wr_addr == ADDR_PATLEN) ? wr_data : patlen_q;
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            src34_q <= SRC_SEL_RST;
            src12_q <= SRC_SEL_RST;
            tbase_q <= TIMEBASE_RST;
            patlen_q <= PATLEN_RST;
        end else begin
            src34_q <= src34_d;
            src12_q <= src12_d;
            tbase_q <= tbase_d;
            patlen_q <= patlen_d;
        end
    end
    logic [3:0] hold_n, per_scale, dly_scale;
    assign hold_n = eff_scale(tbase_q[HOLD_LSB+:4]);
    assign per_scale = eff_scale(tbase_q[PER_BASE_LSB+:4]);
    assign dly_scale = eff_scale(tbase_q[DLY_BASE_LSB+:4]);

    // timebase: period and start-delay prescalers run only while playing
    logic [3:0] ppre_q, ppre_d, dpre_q, dpre_d, hcnt_q, hcnt_d;
    logic [15:0] pcnt_q, pcnt_d, dcnt_q, dcnt_d;
    logic pstart_q, pstart_d, ptick, pwrap, dtick, sample_en;
    logic [3:0] gate;
    always_comb begin
        ptick = ppre_q >= per_scale - 4'h1;
        pwrap = ptick && pcnt_q >= patlen_q - 16'h0001;
        dtick = dpre_q >= dly_scale - 4'h1;
        ppre_d = ptick ? 4'h0 : ppre_q + 4'h1;
        pcnt_d = pwrap ? 16'h0000 : pcnt_q + {15'h0000, ptick};
        dpre_d = (pwrap || dtick) ? 4'h0 : dpre_q + 4'h1;
        dcnt_d = dcnt_q;
        if (pwrap) begin
            dcnt_d = 16'h0000;
        end else if (dtick && dcnt_q != 16'hffff) begin
            dcnt_d = dcnt_q + 16'h0001;
        end
        pstart_d = pwrap;
        if (!pattern_run_in) begin
            ppre_d = 4'h0;
            pcnt_d = 16'h0000;
            dpre_d = 4'h0;
            dcnt_d = 16'h0000;
            pstart_d = 1'b0;
        end
        // a shrunk hold value must not strand the counter above it
        sample_en = hcnt_q >= hold_n - 4'h1;
        hcnt_d = sample_en ? 4'h0 : hcnt_q + 4'h1;
    end

    // per-channel source selection; index 0..3 is channel 1..4
    logic [3:0][11:0] pre, dac_q, dac_d;
    wss_chan_cfg_t [3:0] cfg;
    logic [3:0] mask, active_q;
    assign mask = {src12_q[MASK_HI_BIT], src12_q[MASK_LO_BIT], 2'b00};
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_ch
            localparam int SLSB = (i % 2 == 1) ? SRC_HI_LSB : SRC_LO_LSB;
            localparam int GLSB = (i % 2 == 1) ? GEN_HI_LSB : GEN_LO_LSB;
            logic [15:0] creg;
            logic [11:0] gen_v;
            logic signed [23:0] prod;
            assign creg = (i < 2) ? src12_q : src34_q;
            assign cfg[i] = {wss_gen_t'(creg[GLSB+:2]),
                             wss_src_t'(creg[SLSB+:2])};
            assign gate[i] = pattern_run_in
                             && dcnt_q >= start_offset_in[i];
            always_comb begin
                case (cfg[i].gen)
                    GEN_CONST: gen_v = fixed_level_in[i];
                    GEN_RAMP: gen_v = ramp_in[i];
                    GEN_PRNG: gen_v = prng_in[i];
                    GEN_SYNTH: gen_v = synth_in[i];
                    default: gen_v = fixed_level_in[i];
                endcase
                prod = $signed(gen_v) * $signed(mem_data_in[i]);
                case (cfg[i].src)
                    SRC_MEM: pre[i] = mem_data_in[i];
                    SRC_GEN: pre[i] = gen_v;
                    SRC_GATED: pre[i] = gate[i] ? gen_v : 12'h000;
                    SRC_MOD: pre[i] = prod[MOD_LSB+:12];
                    default: pre[i] = gen_v;
                endcase
                if (mask[i]) begin
                    pre[i] = fixed_level_in[i];
                end
            end
        end
    endgenerate

    always_comb begin
        dac_d = dac_q;
        if (sample_en) begin
            dac_d = pre;
            if (src12_q[SUM_LO_BIT]) begin
                dac_d[0] = sat_add(pre[0], pre[2]);
            end
            if (src12_q[SUM_HI_BIT]) begin
                dac_d[1] = sat_add(pre[1], pre[3]);
            end
        end
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ppre_q <= 4'h0;
            dpre_q <= 4'h0;
            hcnt_q <= 4'h0;
            pcnt_q <= 16'h0000;
            dcnt_q <= 16'h0000;
            pstart_q <= 1'b0;
            active_q <= 4'h0;
            dac_q <= '0;
        end else begin
            ppre_q <= ppre_d;
            dpre_q <= dpre_d;
            hcnt_q <= hcnt_d;
            pcnt_q <= pcnt_d;
            dcnt_q <= dcnt_d;
            pstart_q <= pstart_d;
            active_q <= gate;
            dac_q <= dac_d;
        end
    end
    assign dac_out = dac_q;
    assign chan_active_out = active_q;
    assign period_start_out = pstart_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    mem_path_a: assert property (sample_en && cfg[3].src == SRC_MEM
        && !mask[3] |=> dac_q[3] == $past(mem_data_in[3]))
        else $error("memory source not passed to channel 4");
    gate_off_a: assert property (sample_en && cfg[3].src == SRC_GATED
        && !gate[3] && !mask[3] |=> dac_q[3] == 12'h000)
        else $error("gated channel 4 not silent before its delay");
    src_write_a: assert property (wr_en && wr_addr == ADDR_SRC_CH12
        |=> cfg[1].src == $past(wr_data[9:8])
            && cfg[0].src == $past(wr_data[1:0]))
        else $error("source fields not taken from written word");
    gen_write_a: assert property (wr_en && wr_addr == ADDR_SRC_CH34
        |=> cfg[3].gen == $past(wr_data[13:12])
            && cfg[2].gen == $past(wr_data[5:4]))
        else $error("generator fields not taken from written word");
    const_gen_a: assert property (sample_en && !mask[3]
        && cfg[3].src == SRC_GEN && cfg[3].gen == GEN_CONST
        |=> dac_q[3] == $past(fixed_level_in[3]))
        else $error("constant generator wrong on channel 4");
    mask_const_a: assert property (sample_en && src12_q[11]
        |=> dac_q[3] == $past(fixed_level_in[3]))
        else $error("masked channel 4 not at its constant");
    sum_ch2_a: assert property (sample_en && src12_q[10]
        |=> dac_q[1] == sat_add($past(pre[1]), $past(pre[3])))
        else $error("channel 2 sum wrong");
    ch3_keep_a: assert property (sample_en && src12_q[2]
        |=> dac_q[2] == $past(pre[2]))
        else $error("channel 3 disturbed by summing");
    sat_pos_a: assert property (sample_en && src12_q[2]
        && !pre[0][11] && !pre[2][11] && pre[0] + pre[2] > 12'h7ff
        |=> dac_q[0] == 12'h7ff)
        else $error("channel 1 sum wrapped");
    hold_two_a: assert property (sample_en && hold_n == 4'h2 && !wr_en
        |=> !sample_en ##1 (sample_en || $past(wr_en)))
        else $error("hold of two not honoured");
    period_two_a: assert property ((pstart_q && pattern_run_in
        && patlen_q == 16'h0002 && per_scale == 4'h1 && !wr_en)
        ##1 pattern_run_in |-> !pstart_q ##1 pstart_q)
        else $error("pattern period of two units not kept");
    delay_two_a: assert property ((pstart_q && pattern_run_in
        && dly_scale == 4'h1 && per_scale == 4'h1 && patlen_q > 16'h0004
        && start_offset_in[3] == 16'h0002 && !wr_en) ##1 pattern_run_in[*2]
        |=> chan_active_out[3])
        else $error("start delay of two units not kept");
endmodule : wss_top

// ---- testbench/wss_spi_host.sv ----
`timescale 1ns/10ps
module wss_spi_host (
    input wire logic clock_in,
    input wire logic sdo_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    // clocks per serial phase; the block needs three to see each edge
    localparam int HALF = 5;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : step

    // one 32-bit frame, msb first; data bits are read back as they pass
    task automatic frame(input logic [31:0] word, output logic [15:0] rdata);
        step(1);
        cs_n_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            sdi_out = word[i];
            step(HALF);
            if (i < 16) begin
                rdata[i] = sdo_in;
            end
            sclk_out = 1'b1;
            step(HALF);
            sclk_out = 1'b0;
        end
        // a released line must not keep showing the last bit
        sdi_out = ~sdi_out;
        step(HALF);
        cs_n_out = 1'b1;
        step(4);
    endtask : frame
endmodule : wss_spi_host

// ---- testbench/wss_top_test.sv ----
`timescale 1ns/10ps
module wss_top_test
    import wss_pkg::*;
();
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe_n;
    logic run = 1'b0;
    logic [3:0][11:0] mem = '0, ramp = '0, prng = '0, synth = '0, fixed = '0;
    logic [3:0][15:0] offs = '0;
    logic [3:0][11:0] dac;
    logic [3:0] act;
    logic pstart;
    // pull-up on the read line while the block releases it
    wire sdo_line = sdo_oe_n ? 1'b1 : sdo;
    int n_errors = 0;
    int total_checks = 0;

    always #20 clock_in = ~clock_in;

    wss_top dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_sdi_in(sdi),
        .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n),
        .pattern_run_in(run), .mem_data_in(mem), .ramp_in(ramp),
        .prng_in(prng), .synth_in(synth), .fixed_level_in(fixed),
        .start_offset_in(offs), .dac_out(dac), .chan_active_out(act),
        .period_start_out(pstart));

    wss_spi_host host_u (.clock_in(clock_in), .sdo_in(sdo_line),
        .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host_u.frame({1'b0, a, d}, unused);
    endtask : wr

    task automatic rd(input logic [14:0] a, output logic [15:0] d);
        host_u.frame({1'b1, a, 16'h0000}, d);
    endtask : rd

    function automatic logic [11:0] sat(logic [11:0] a, logic [11:0] b);
        logic signed [12:0] s;
        s = $signed(a) + $signed(b);
        if (s > 13'sd2047) return 12'h7ff;
        if (s < -13'sd2048) return 12'h800;
        return s[11:0];
    endfunction : sat

    function automatic logic [11:0] modv(logic [11:0] a, logic [11:0] b);
        logic signed [23:0] p;
        p = $signed(a) * $signed(b);
        return p[22:11];
    endfunction : modv

    task automatic t_reset_values();
        logic [15:0] v;
        check("dac0 at reset", 16'(dac[0]), 16'h0000);
        rd(15'h026, v);
        check("src ch34 reset", v, 16'h0101);
        rd(15'h027, v);
        check("src ch12 reset", v, 16'h0101);
        rd(15'h028, v);
        check("timebase reset", v, 16'h0111);
        rd(15'h029, v);
        check("length reset", v, 16'h8000);
        wr(15'h02a, 16'h1234);
        rd(15'h02a, v);
        check("unmapped read", v, 16'h0000);
    endtask : t_reset_values

    task automatic t_gen_codes();
        logic [15:0] v;
        logic [15:0] back;
        logic [11:0] e;
        for (int c = 0; c < 4; c++) begin
            fixed[c] = 12'h100 + 12'(c);
            ramp[c] = 12'h200 + 12'(c);
            prng[c] = 12'h300 + 12'(c);
            synth[c] = 12'h400 + 12'(c);
        end
        for (int g = 0; g < 4; g++) begin
            v = 16'h0101 | 16'(g << 12) | 16'(g << 4);
            wr(ADDR_SRC_CH34, v);
            wr(ADDR_SRC_CH12, v);
            rd(ADDR_SRC_CH12, back);
            check("src ch12 back", back, v);
            cyc(3);
            for (int c = 0; c < 4; c++) begin
                e = g == 0 ? fixed[c] : g == 1 ? ramp[c] :
                    g == 2 ? prng[c] : synth[c];
                check("gen out", 16'(dac[c]), 16'(e));
            end
        end
    endtask : t_gen_codes

    task automatic t_src_modes();
        fixed = {12'h123, 12'h7ff, 12'hc00, 12'h400};
        mem = {12'h456, 12'h801, 12'h200, 12'h200};
        for (int s = 0; s < 4; s += 3) begin
            wr(ADDR_SRC_CH34, 16'(s << 8 | s));
            wr(ADDR_SRC_CH12, 16'(s << 8 | s));
            cyc(3);
            for (int c = 0; c < 4; c++) begin
                check("src out", 16'(dac[c]),
                      16'(s == 0 ? mem[c] : modv(fixed[c], mem[c])));
            end
        end
        wr(ADDR_SRC_CH34, 16'h0202);
        wr(ADDR_SRC_CH12, 16'h0202);
        cyc(4);
        check("gated idle", 16'(act), 16'h0000);
        check("gated idle dac", 16'(dac[0]), 16'h0000);
        wr(ADDR_PATLEN, 16'h0008);
        offs = {16'hffff, 16'h0000, 16'hffff, 16'h0000};
        run = 1'b1;
        cyc(20);
        check("gated active", 16'(act), 16'h0005);
        check("gated on", 16'(dac[0]), 16'(fixed[0]));
        check("gated off", 16'(dac[1]), 16'h0000);
    endtask : t_src_modes

    task automatic t_mask_sum();
        wr(ADDR_SRC_CH34, 16'h1111);
        wr(ADDR_SRC_CH12, 16'h1919);
        cyc(3);
        check("mask ch3", 16'(dac[2]), 16'(fixed[2]));
        check("mask ch4", 16'(dac[3]), 16'(fixed[3]));
        check("mask ch1 free", 16'(dac[0]), 16'(ramp[0]));
        wr(ADDR_SRC_CH12, 16'h1d1d);
        for (int k = 0; k < 2; k++) begin
            ramp[1:0] = k == 0 ? {12'h100, 12'h010} : {12'h900, 12'h7f0};
            fixed[3:2] = k == 0 ? {12'h0ff, 12'h020} : {12'h900, 12'h020};
            cyc(3);
            check("sum ch1", 16'(dac[0]),
                  16'(sat(ramp[0], fixed[2])));
            check("sum ch2", 16'(dac[1]),
                  16'(sat(ramp[1], fixed[3])));
            check("ch3 kept", 16'(dac[2]), 16'(fixed[2]));
        end
    endtask : t_mask_sum

    task automatic t_hold();
        logic [11:0] prev;
        int cnt;
        wr(ADDR_SRC_CH12, 16'h1111);
        for (int h = 0; h < 5; h += (h == 0 ? 2 : 1)) begin
            wr(ADDR_TIMEBASE, 16'h0011 | 16'(h << 8));
            cnt = 0;
            prev = dac[0];
            for (int i = 0; i < 24; i++) begin
                ramp[0] = ramp[0] + 12'h001;
                cyc(1);
                cnt += int'(dac[0] !== prev);
                prev = dac[0];
            end
            check("hold updates", 16'(cnt), 16'(24 / (h == 0 ? 1 : h)));
        end
    endtask : t_hold

    task automatic to_pulse(output int n);
        n = 0;
        cyc(1);
        while (pstart !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
    endtask : to_pulse

    task automatic to_active(output int m);
        logic prev;
        m = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && act[0] === 1'b1) && m < 100) begin
            prev = act[0];
            cyc(1);
            m++;
        end
    endtask : to_active

    task automatic t_period_delay();
        int n;
        int d[3];
        logic [3:0] lens[3] = '{4'h2, 4'h3, 4'h2};
        logic [3:0] scl[3] = '{4'h1, 4'h0, 4'h3};
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_PATLEN, 16'(lens[k]));
            wr(ADDR_TIMEBASE, 16'h0101 | 16'(scl[k] << 4));
            to_pulse(n);
            to_pulse(n);
            check("period gap", 16'(n + 1),
                  16'(lens[k] * (scl[k] == 0 ? 1 : scl[k])));
        end
        wr(ADDR_PATLEN, 16'h0008);
        offs = {16'h0002, 16'h0000, 16'h0000, 16'h0003};
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_TIMEBASE, 16'h0110 | 16'(s));
            to_pulse(n);
            to_pulse(n);
            to_active(d[s]);
        end
        check("delay zero scale", 16'(d[0]), 16'(d[1]));
        check("delay scale two", 16'(d[2] - d[1]), 16'h0003);
    endtask : t_period_delay

    initial begin
        #2_000_000;
        n_errors++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clock_in);
        #1 rst_n_in = 1'b1;
        cyc(4);
        t_reset_values();
        t_gen_codes();
        t_src_modes();
        t_mask_sum();
        t_hold();
        t_period_delay();
        final_report();
    end
endmodule : wss_top_test
